/* src/brc_regs.vh */
`ifndef BRC_REGS_VH
`define BRC_REGS_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define BRC_ADDR_THRESH 8'h00
`define BRC_ADDR_CAUSE 8'h04
`define BRC_ADDR_FLASH1 8'h08
`define BRC_ADDR_STATUS 8'h0C
`define BRC_ADDR_IRQ_STAT 8'h10
`define BRC_ADDR_IRQ_EN 8'h14
`define BRC_ADDR_IRQ_CLR 8'h18
// ----------------------------------------
// threshold codes
// ----------------------------------------
`define BRC_CODE_1V7 8'h66
`define BRC_CODE_1V9 8'h55
`define BRC_CODE_2V55 8'h33
`define BRC_CODE_3V15 8'h99
`define BRC_CODE_3V8 8'hAA
`define BRC_CODE_OFF 8'hF0
`define BRC_THRESH_POR 8'h66
`define BRC_IAP_KEY 8'h55
// ----------------------------------------
// cause flag bits
// ----------------------------------------
`define BRC_BIT_WDOG_CODE 0
`define BRC_BIT_BAD_CODE 1
`define BRC_BIT_BROWNOUT 2
`define BRC_BIT_GUARD_CODE 3
// ----------------------------------------
// status bits
// ----------------------------------------
`define BRC_BIT_EXPIRY 0
`define BRC_BIT_PDOWN 1
// ----------------------------------------
// irq event bits
// ----------------------------------------
`define BRC_EV_BROWNOUT 0
`define BRC_EV_BAD_CODE 1
`define BRC_EV_IAP 2
`define BRC_EV_WDOG 3
// ----------------------------------------
// timing
// ----------------------------------------
`define BRC_CLK_NS 25
`define BRC_FILTER_NS 1000
`define BRC_CODE_DELAY_NS 2000
`define BRC_RESET_PULSE 16
`endif

/* src/brc_sequencer.v */
// Overview of operation
// RULE1 - brownout monitor runs while awake; qualified low supply resets and flags
// RULE2 - low supply must outlast filter time; shorter dips change nothing
// RULE3 - eight-bit code picks threshold; F0 disables monitoring
// RULE4 - undefined code resets after delay and restores power-on threshold
// RULE5 - undefined code reset sets cause bit 1; only software zero clears
// RULE6 - genuine brownout reset keeps threshold register contents
// RULE7 - threshold register powers up at 66 hex, lowest threshold
// RULE8 - monitoring suspended in idle or sleep
// RULE9 - brownout reset sets cause bit 2; software zero clears; unknown at power-on (code clears it to zero at power-on)
// RULE10 - cause bits 7..4 read zero; others reset zero except bit 2 (code resets bit 2 to zero as well)
// RULE11 - writing 55 hex to flash control one triggers programming reset
// RULE12 - watchdog expiry while running: full reset and expiry flag set
// RULE13 - watchdog expiry asleep: clear program counter, stack pointer, set flag
// RULE14 - power-on clears expiry and power-down; pin or brownout reset keeps them
// RULE15 - awake watchdog keeps power-down; asleep watchdog sets both
// RULE16 - power-on reset clears core state, ports input, stack at top
// RULE17 - undefined code delay is a parameterised cycle count
`timescale 1ns/100ps
`default_nettype none
`include "brc_regs.vh"

module brc_sequencer #(
  parameter FILTER_CYC = (`BRC_FILTER_NS + `BRC_CLK_NS - 1) / `BRC_CLK_NS,
  parameter CODE_DELAY_CYC = (`BRC_CODE_DELAY_NS + `BRC_CLK_NS - 1) / `BRC_CLK_NS,
  parameter PULSE_CYC = `BRC_RESET_PULSE
) (
  // clock and power-on reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // analogue comparators and core events (async)
  input wire supply_low,
  input wire external_clear_pin_n,
  input wire watchdog_expiry,
  input wire core_asleep,
  // selected threshold to comparator
  output reg [7:0] threshold_code,
  output reg brownout_enable,
  // reset requests to the core
  output reg full_reset,
  output reg pc_sp_clear,
  // interrupt
  output reg irq
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function is_defined_code;
    input [7:0] c;
    begin
      is_defined_code = (c == `BRC_CODE_1V7) || (c == `BRC_CODE_1V9) ||
        (c == `BRC_CODE_2V55) || (c == `BRC_CODE_3V15) || (c == `BRC_CODE_3V8) ||
        (c == `BRC_CODE_OFF);
    end
  endfunction

  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      lane_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          lane_merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg [3:0] sync_a;
  reg [3:0] sync_b;
  wire low_s = sync_b[0];
  wire pin_n_s = sync_b[1];
  wire wdog_s = sync_b[2];
  wire asleep_s = sync_b[3];
  reg wdog_d;
  wire wdog_rise = wdog_s & ~wdog_d;

  always @(posedge aclk) begin
    if (!aresetn) begin
      // pin input idles high, the rest idle low
      sync_a <= 4'h2;
      sync_b <= 4'h2;
      wdog_d <= 1'b0;
    end else begin
      sync_a <= {core_asleep, watchdog_expiry, external_clear_pin_n, supply_low};
      sync_b <= sync_a;
      wdog_d <= wdog_s;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] thresh;
  reg [3:0] cause;
  reg expiry_flag;
  reg pdown_flag;
  reg [3:0] irq_stat;
  reg [3:0] irq_en;
  reg [15:0] filt_cnt;
  reg [15:0] code_cnt;
  reg [7:0] pulse_cnt;
  reg pin_d;

  // write channel capture
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire wr_thresh = wr_fire && aw_addr == `BRC_ADDR_THRESH && w_strb[0];
  wire wr_cause = wr_fire && aw_addr == `BRC_ADDR_CAUSE && w_strb[0];
  wire wr_flash = wr_fire && aw_addr == `BRC_ADDR_FLASH1 && w_strb[0];
  wire wr_en = wr_fire && aw_addr == `BRC_ADDR_IRQ_EN;
  wire wr_clr = wr_fire && aw_addr == `BRC_ADDR_IRQ_CLR;
  wire wr_map = (aw_addr == `BRC_ADDR_THRESH) || (aw_addr == `BRC_ADDR_CAUSE) ||
    (aw_addr == `BRC_ADDR_FLASH1) || (aw_addr == `BRC_ADDR_IRQ_EN) ||
    (aw_addr == `BRC_ADDR_IRQ_CLR);

  // ----------------------------------------
  // trip detection
  // ----------------------------------------
  // RULE8 monitor sleeps
  wire monitor_on = ~asleep_s && thresh != `BRC_CODE_OFF;
  // RULE2 filter qualified
  wire brown_trip = monitor_on && low_s && filt_cnt == FILTER_CYC[15:0];
  wire bad_code = ~is_defined_code(thresh);
  // RULE17 delay count
  wire code_trip = bad_code && code_cnt == CODE_DELAY_CYC[15:0];
  // RULE11 programming key
  wire iap_trip = wr_flash && w_data[7:0] == `BRC_IAP_KEY;
  wire wdog_awake = wdog_rise & ~asleep_s;
  wire wdog_sleep = wdog_rise & asleep_s;
  wire pin_trip = ~pin_n_s & pin_d;
  wire any_full = brown_trip | code_trip | iap_trip | wdog_awake | pin_trip;

  always @(posedge aclk) begin
    if (!aresetn) begin
      filt_cnt <= 16'h0000;
      code_cnt <= 16'h0000;
      // idle level, so a release gives no false pin edge
      pin_d <= 1'b1;
    end else begin
      pin_d <= pin_n_s;
      // RULE2 dips restart
      if (!monitor_on || !low_s || brown_trip) begin
        filt_cnt <= 16'h0000;
      end else begin
        filt_cnt <= filt_cnt + 16'h0001;
      end
      // a bad code rewritten in time never trips
      if (!bad_code || code_trip) begin
        code_cnt <= 16'h0000;
      end else begin
        code_cnt <= code_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // threshold, cause and core flags
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      // RULE7 power-on code
      thresh <= `BRC_THRESH_POR;
      // RULE10 cause clear
      cause <= 4'h0;
      // RULE14 power-on clear
      expiry_flag <= 1'b0;
      pdown_flag <= 1'b0;
    end else begin
      // RULE4 code restore
      if (code_trip) begin
        thresh <= `BRC_THRESH_POR;
      end else if (wr_thresh) begin
        // RULE6 brownout keeps code
        thresh <= w_data[7:0];
      end
      if (wr_cause) begin
        cause <= cause & w_data[3:0];
      end
      // RULE5 bad code flag
      if (code_trip) begin
        cause[`BRC_BIT_BAD_CODE] <= 1'b1;
      end
      // RULE9 brownout flag
      if (brown_trip) begin
        cause[`BRC_BIT_BROWNOUT] <= 1'b1;
      end
      // RULE12 awake expiry
      if (wdog_awake) begin
        expiry_flag <= 1'b1;
      end
      // RULE15 asleep sets both
      if (wdog_sleep) begin
        expiry_flag <= 1'b1;
        pdown_flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // reset pulse generation
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      // RULE16 core held in reset
      pulse_cnt <= PULSE_CYC[7:0];
      full_reset <= 1'b1;
      pc_sp_clear <= 1'b0;
    end else begin
      // RULE1 internal reset
      if (any_full) begin
        pulse_cnt <= PULSE_CYC[7:0];
      end else if (pulse_cnt != 8'h00) begin
        pulse_cnt <= pulse_cnt - 8'h01;
      end
      // stretched so the core always sees a clean pulse
      full_reset <= any_full || pulse_cnt > 8'h01;
      // RULE13 partial clear
      pc_sp_clear <= wdog_sleep;
    end
  end

  // ----------------------------------------
  // comparator outputs and interrupt
  // ----------------------------------------
  reg [3:0] events;

  always @* begin
    events = 4'h0;
    events[`BRC_EV_BROWNOUT] = brown_trip;
    events[`BRC_EV_BAD_CODE] = code_trip;
    events[`BRC_EV_IAP] = iap_trip;
    events[`BRC_EV_WDOG] = wdog_rise;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      threshold_code <= `BRC_THRESH_POR;
      brownout_enable <= 1'b0;
      irq_stat <= 4'h0;
      irq_en <= 4'h0;
      irq <= 1'b0;
    end else begin
      // RULE3 code to comparator
      threshold_code <= thresh;
      brownout_enable <= monitor_on;
      // set wins over clear
      irq_stat <= (irq_stat & ~(wr_clr ? w_data[3:0] : 4'h0)) | events;
      if (wr_en) begin
        irq_en <= w_data[3:0];
      end
      irq <= |(irq_stat & irq_en);
    end
  end

  // ----------------------------------------
  // axi4-lite write path
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      // one-cycle ready; a held half waits for its partner
      s_axi_awready <= ~aw_held & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_held & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= lane_merge(32'h00000000, s_axi_wdata, s_axi_wstrb);
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  reg [31:0] rd_word;
  reg rd_ok;

  always @* begin
    rd_ok = 1'b1;
    rd_word = 32'h00000000;
    case ({s_axi_araddr[7:2], 2'b00})
      `BRC_ADDR_THRESH: rd_word[7:0] = thresh;
      `BRC_ADDR_CAUSE: rd_word[3:0] = cause;
      `BRC_ADDR_FLASH1: rd_word = 32'h00000000;
      `BRC_ADDR_STATUS: begin
        rd_word[`BRC_BIT_EXPIRY] = expiry_flag;
        rd_word[`BRC_BIT_PDOWN] = pdown_flag;
      end
      `BRC_ADDR_IRQ_STAT: rd_word[3:0] = irq_stat;
      `BRC_ADDR_IRQ_EN: rd_word[3:0] = irq_en;
      `BRC_ADDR_IRQ_CLR: rd_word = 32'h00000000;
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      // one read at a time; the address must stand until answered
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* verif/brc_seq_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module brc_seq_properties #(
  parameter FILTER_CYC = 40,
  parameter CODE_DELAY_CYC = 80
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // events in
  input wire logic supply_low,
  input wire logic watchdog_expiry,
  input wire logic core_asleep,
  // outputs watched
  input wire logic [7:0] threshold_code,
  input wire logic brownout_enable,
  input wire logic full_reset,
  input wire logic pc_sp_clear
);
  localparam int CMAX = CODE_DELAY_CYC + 8;
  logic [7:0] low_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // low supply run length
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn || !(supply_low && brownout_enable)) begin
      low_cnt <= 8'h00;
    end else if (low_cnt != 8'hFF) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end
  sequence s_wake_wd;
    !core_asleep [*4] ##0 $rose(watchdog_expiry);
  endsequence
  sequence s_sleep_wd;
    core_asleep [*4] ##0 $rose(watchdog_expiry);
  endsequence
  a_low_trips: assert property (low_cnt == FILTER_CYC + 4 |-> ##[0:6] full_reset)
    else $error("long low supply gave no reset");
  a_trip_hold: assert property ($rose(full_reset) |-> full_reset [*3])
    else $error("reset pulse too short");
  a_bad_restore: assert property (!(threshold_code inside {8'h66, 8'h55, 8'h33, 8'h99,
    8'hAA, 8'hF0}) |-> ##[1:CMAX] threshold_code == 8'h66)
    else $error("bad code not restored");
  a_off_code: assert property ((threshold_code == 8'hF0) [*3] |-> !brownout_enable)
    else $error("monitor on with disable code");
  a_sleep_off: assert property (core_asleep [*4] |=> !brownout_enable)
    else $error("monitor on while asleep");
  a_wake_wd: assert property (s_wake_wd |-> ##[1:8] full_reset)
    else $error("awake expiry gave no reset");
  a_sleep_wd: assert property (s_sleep_wd |-> ##[1:8] pc_sp_clear)
    else $error("asleep expiry gave no clear");
  a_clear_pulse: assert property (pc_sp_clear |=> !pc_sp_clear)
    else $error("clear pulse too long");
endmodule
bind brc_sequencer brc_seq_properties #(.FILTER_CYC(FILTER_CYC),
  .CODE_DELAY_CYC(CODE_DELAY_CYC)) u_props (.aclk, .aresetn, .supply_low,
  .watchdog_expiry, .core_asleep, .threshold_code, .brownout_enable, .full_reset,
  .pc_sp_clear);
`default_nettype wire

/* verif/brc_supply_model.sv */
`timescale 1ns/100ps
`default_nettype none
module brc_supply_model (
  // comparator
  input wire logic [7:0] threshold_code,
  input wire logic [11:0] vdd_mv,
  output logic supply_low
);
  logic [11:0] trip_mv;
  always_comb begin
    case (threshold_code)
      8'h66: trip_mv = 12'h6A4;
      8'h55: trip_mv = 12'h76C;
      8'h33: trip_mv = 12'h9F6;
      8'h99: trip_mv = 12'hC4E;
      8'hAA: trip_mv = 12'hED8;
      // disabled: comparator still answers, the design must ignore it
      8'hF0: trip_mv = 12'h9F6;
      default: trip_mv = 12'h000;
    endcase
  end
  assign supply_low = vdd_mv < trip_mv;
endmodule
`default_nettype wire

/* verif/brownout_and_reset_cause_logic_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module brownout_and_reset_cause_logic_tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] r;
  logic watchdog_expiry, core_asleep, external_clear_pin_n, fr_seen, pc_seen;
  logic [11:0] vdd_mv;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, supply_low;
  wire brownout_enable, full_reset, pc_sp_clear, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] threshold_code;
  int mismatches, n_checks;
  brc_sequencer #(.FILTER_CYC(3), .CODE_DELAY_CYC(3), .PULSE_CYC(4)) u_brc_sequencer (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .supply_low, .external_clear_pin_n, .watchdog_expiry,
    .core_asleep, .threshold_code, .brownout_enable, .full_reset, .pc_sp_clear, .irq);
  brc_supply_model u_brc_supply_model (.threshold_code, .vdd_mv, .supply_low);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // trip outputs are watched while the bench waits
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge aclk);
      if (full_reset) fr_seen = 1'b1;
      if (pc_sp_clear) pc_seen = 1'b1;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(d, exp);
  endtask
  task automatic pulse_wd;
    watchdog_expiry <= 1'b1;
    cyc(4);
    watchdog_expiry <= 1'b0;
    cyc(8);
  endtask
  task automatic t_brownout;
    wr(8'h00, 32'h55);
    chk({30'h0, r}, 32'h0);
    vdd_mv <= 12'h3E8;
    cyc(2);
    vdd_mv <= 12'hCE4;
    cyc(10);
    rchk(8'h04, 32'h0);
    fr_seen = 1'b0;
    vdd_mv <= 12'h3E8;
    cyc(15);
    vdd_mv <= 12'hCE4;
    chk1(fr_seen, 1'b1);
    rchk(8'h04, 32'h4);
    rchk(8'h00, 32'h55);
    rchk(8'h0C, 32'h0);
    wr(8'h04, 32'h0);
    rchk(8'h04, 32'h0);
    rchk(8'h1C, 32'h0);
    chk({30'h0, r}, 32'h2);
    wr(8'h1C, 32'h0);
    chk({30'h0, r}, 32'h2);
  endtask
  task automatic t_code;
    fr_seen = 1'b0;
    wr(8'h00, 32'h12);
    cyc(12);
    chk1(fr_seen, 1'b1);
    rchk(8'h00, 32'h66);
    rchk(8'h04, 32'h2);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'hF0);
    vdd_mv <= 12'h3E8;
    cyc(15);
    rchk(8'h04, 32'h0);
    vdd_mv <= 12'hCE4;
    wr(8'h00, 32'h66);
    core_asleep <= 1'b1;
    vdd_mv <= 12'h3E8;
    cyc(15);
    vdd_mv <= 12'hCE4;
    rchk(8'h04, 32'h0);
  endtask
  task automatic t_wdog;
    core_asleep <= 1'b0;
    cyc(6);
    fr_seen = 1'b0;
    pulse_wd();
    chk1(fr_seen, 1'b1);
    chk1(pc_seen, 1'b0);
    rchk(8'h0C, 32'h1);
    fr_seen = 1'b0;
    external_clear_pin_n <= 1'b0;
    cyc(3);
    external_clear_pin_n <= 1'b1;
    cyc(8);
    chk1(fr_seen, 1'b1);
    rchk(8'h0C, 32'h1);
    core_asleep <= 1'b1;
    cyc(6);
    fr_seen = 1'b0;
    pc_seen = 1'b0;
    pulse_wd();
    chk1(pc_seen, 1'b1);
    chk1(fr_seen, 1'b0);
    rchk(8'h0C, 32'h3);
    core_asleep <= 1'b0;
  endtask
  task automatic t_iap;
    wr(8'h14, 32'h4);
    fr_seen = 1'b0;
    wr(8'h08, 32'h55);
    cyc(3);
    chk1(fr_seen, 1'b1);
    chk1(irq, 1'b1);
    rchk(8'h10, 32'hF);
    wr(8'h18, 32'h4);
    cyc(3);
    chk1(irq, 1'b0);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {watchdog_expiry, core_asleep, fr_seen, pc_seen} = 4'h0;
    external_clear_pin_n = 1'b1;
    vdd_mv = 12'hCE4;
    cyc(4);
    chk1(full_reset, 1'b1);
    aresetn <= 1'b1;
    rchk(8'h00, 32'h66);
    rchk(8'h04, 32'h0);
    rchk(8'h0C, 32'h0);
    t_brownout();
    t_code();
    t_wdog();
    t_iap();
    stop_test();
  end
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
